// *** src/ime_pkg.sv ***
// package for the two-wire master transfer engine: constants and carrier types
package ime_pkg;
    localparam int unsigned IME_BYTE_BITS = 8;
    localparam logic [3:0] IME_LAST_BIT = 4'h7;
    localparam logic [3:0] IME_ACK_SLOT = 4'h8;
    localparam logic [7:0] IME_BAUD_RST = 8'h4F;
    localparam logic [7:0] IME_BYTE_RST = 8'h00;
    localparam logic [3:0] IME_CNT_RST = 4'h0;
    localparam logic [7:0] IME_ZERO8 = 8'h00;
    localparam int unsigned IME_FIFO_DEPTH = 8;

    typedef enum logic [3:0] {
        ST_IDLE, ST_START_A, ST_START_B, ST_RST_A, ST_RST_B, ST_RST_C,
        ST_TX_LOW, ST_TX_HIGH, ST_RX_LOW, ST_RX_HIGH,
        ST_ACK_LOW, ST_ACK_HIGH, ST_STOP_A, ST_STOP_B, ST_STOP_C, ST_STOP_D
    } ime_state_t;

    // pin pair for one open-drain line
    typedef struct packed {
        logic o;
        logic oe;
    } ime_pin_t;

    // software request bits
    typedef struct packed {
        logic begin_request;
        logic restart_request;
        logic stop_request;
        logic receive_request;
        logic ack_sequence_request;
    } ime_req_t;

    // status flags
    typedef struct packed {
        logic buffer_full;
        logic write_collision_flag;
        logic ack_result_bit;
        logic receive_overflow_flag;
        logic serial_port_irq_flag;
        logic bus_collision_flag;
        logic begin_detected_bit;
        logic end_detected_flag;
    } ime_flags_t;
endpackage : ime_pkg

// *** src/ime_fifo.sv ***
// small valid/ready fifo for received bytes
`timescale 1ns/1ps
`default_nettype none
module ime_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } ime_fifo_st_t;
    ime_fifo_st_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;

    assign empty = (st.wp == st.rp);
    assign full = (st.wp[AW-1:0] == st.rp[AW-1:0]) && (st.wp[AW] != st.rp[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[st.rp[AW-1:0]];

    always_comb begin
        next_st = st;
        if (in_valid && !full) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            next_st.rp = st.rp + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (in_valid && !full) begin
            mem[st.wp[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ime_fifo
`default_nettype wire

// *** src/ime_master.sv ***
// two-wire bus master transfer engine with byte shifter, flags and bus monitor
`timescale 1ns/1ps
`default_nettype none
module ime_master
    import ime_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic port_enable,
    input wire logic [7:0] baud_reload_reg,
    input wire logic wr_buffer,
    input wire logic [7:0] wr_data,
    input wire logic rd_buffer,
    input wire logic set_begin,
    input wire logic set_restart,
    input wire logic set_stop,
    input wire logic set_receive,
    input wire logic set_ack_sequence,
    input wire logic ack_value_bit,
    input wire logic clr_irq,
    input wire logic clr_write_collision,
    input wire logic clr_overflow,
    input wire logic clr_bus_collision,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [7:0] xfer_buffer,
    output ime_flags_t flags,
    output ime_req_t reqs,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready
);
    typedef struct packed {
        ime_state_t state;
        logic [7:0] brg;
        logic brg_run;
        logic [7:0] shift_register;
        logic [3:0] bit_cnt;
        logic receiving;
        logic [7:0] xfer_buffer;
        ime_flags_t flags;
        ime_req_t reqs;
        logic scl_low;
        logic sda_low;
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_prev;
        logic sda_prev;
        logic bus_busy;
        logic [7:0] rx_data;
        logic rx_push;
    } ime_st_t;

    ime_st_t st, next_st;
    logic scl_s;
    logic sda_s;
    logic tick;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;

    assign scl_s = st.scl_sync[1];
    assign sda_s = st.sda_sync[1];
    assign tick = st.brg_run && (st.brg == IME_ZERO8);

    // received bytes also stream out; a full fifo refuses the next receive request
    ime_fifo #(.WIDTH(IME_BYTE_BITS), .DEPTH(IME_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .in_data(st.rx_data),
        .in_valid(st.rx_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(rx_ready)
    );

    always_comb begin
        next_st = st;
        next_st.rx_push = 1'b0;
        next_st.scl_sync = {st.scl_sync[0], scl_i};
        next_st.sda_sync = {st.sda_sync[0], sda_i};
        next_st.scl_prev = scl_s;
        next_st.sda_prev = sda_s;

        // baud down-counter
        if (st.brg_run) begin
            next_st.brg = (st.brg == IME_ZERO8) ? baud_reload_reg : st.brg - 8'h01;
        end

        // software flag clears first so a same-cycle hardware set wins
        if (clr_irq) next_st.flags.serial_port_irq_flag = 1'b0;
        if (clr_write_collision) next_st.flags.write_collision_flag = 1'b0;
        if (clr_overflow) next_st.flags.receive_overflow_flag = 1'b0;
        if (clr_bus_collision) next_st.flags.bus_collision_flag = 1'b0;
        if (rd_buffer && st.receiving && st.state == ST_IDLE) begin
            next_st.flags.buffer_full = 1'b0;
        end

        // bus monitor: start and stop detection
        if (st.scl_prev && scl_s && st.sda_prev && !sda_s) begin
            next_st.flags.begin_detected_bit = 1'b1;
            next_st.flags.end_detected_flag = 1'b0;
            next_st.bus_busy = 1'b1;
        end
        if (st.scl_prev && scl_s && !st.sda_prev && sda_s) begin
            next_st.flags.end_detected_flag = 1'b1;
            next_st.flags.begin_detected_bit = 1'b0;
            next_st.bus_busy = 1'b0;
            if (st.bus_busy && st.state == ST_IDLE) begin
                next_st.flags.serial_port_irq_flag = 1'b1;
            end
        end

        // buffer writes: accepted only when idle
        if (wr_buffer) begin
            if (st.state != ST_IDLE) begin
                next_st.flags.write_collision_flag = 1'b1;
            end else begin
                next_st.xfer_buffer = wr_data;
                next_st.shift_register = wr_data;
                next_st.flags.buffer_full = 1'b1;
                next_st.receiving = 1'b0;
                next_st.bit_cnt = IME_CNT_RST;
                next_st.sda_low = !wr_data[7];
                next_st.scl_low = 1'b1;
                next_st.brg = baud_reload_reg;
                next_st.brg_run = 1'b1;
                next_st.state = ST_TX_LOW;
            end
        end

        // request bits: only one sequence, taken only when idle
        if (st.state == ST_IDLE && !wr_buffer) begin
            if (set_begin) begin
                next_st.reqs.begin_request = 1'b1;
                next_st.sda_low = 1'b0;
                next_st.scl_low = 1'b0;
                next_st.brg = baud_reload_reg;
                next_st.brg_run = 1'b1;
                next_st.state = ST_START_A;
            end else if (set_restart) begin
                next_st.reqs.restart_request = 1'b1;
                next_st.scl_low = 1'b1;
                next_st.sda_low = 1'b0;
                next_st.brg = baud_reload_reg;
                next_st.brg_run = 1'b1;
                next_st.state = ST_RST_A;
            end else if (set_stop) begin
                next_st.reqs.stop_request = 1'b1;
                next_st.sda_low = 1'b1;
                next_st.state = ST_STOP_A;
            end else if (set_receive && fifo_in_ready) begin
                next_st.reqs.receive_request = 1'b1;
                next_st.receiving = 1'b1;
                next_st.sda_low = 1'b0;
                next_st.scl_low = 1'b1;
                next_st.bit_cnt = IME_CNT_RST;
                next_st.brg = baud_reload_reg;
                next_st.brg_run = 1'b1;
                next_st.state = ST_RX_LOW;
            end else if (set_ack_sequence) begin
                next_st.reqs.ack_sequence_request = 1'b1;
                next_st.scl_low = 1'b1;
                next_st.sda_low = !ack_value_bit;
                next_st.brg = baud_reload_reg;
                next_st.brg_run = 1'b1;
                next_st.state = ST_ACK_LOW;
            end
        end

        unique case (st.state)
            ST_IDLE: begin
            end
            ST_START_A: if (tick) begin
                next_st.sda_low = 1'b1;
                next_st.state = ST_START_B;
            end
            ST_START_B: if (tick) begin
                next_st.reqs.begin_request = 1'b0;
                next_st.flags.serial_port_irq_flag = 1'b1;
                next_st.brg_run = 1'b0;
                next_st.scl_low = 1'b1;
                next_st.state = ST_IDLE;
            end
            ST_RST_A: if (tick) begin
                next_st.scl_low = 1'b0;
                next_st.brg_run = 1'b0;
                next_st.state = ST_RST_B;
            end
            ST_RST_B: if (scl_s) begin
                next_st.brg = baud_reload_reg;
                next_st.brg_run = 1'b1;
                next_st.state = ST_RST_C;
            end
            ST_RST_C: if (tick) begin
                if (!st.sda_low) begin
                    next_st.sda_low = 1'b1;
                end else begin
                    next_st.scl_low = 1'b1;
                    next_st.brg_run = 1'b0;
                    next_st.reqs.restart_request = 1'b0;
                    next_st.flags.serial_port_irq_flag = 1'b1;
                    next_st.state = ST_IDLE;
                end
            end
            ST_TX_LOW, ST_RX_LOW, ST_ACK_LOW: if (tick) begin
                next_st.scl_low = 1'b0;
                next_st.brg_run = 1'b0;
                next_st.state = (st.state == ST_TX_LOW) ? ST_TX_HIGH :
                                (st.state == ST_RX_LOW) ? ST_RX_HIGH : ST_ACK_HIGH;
            end
            ST_TX_HIGH: begin
                if (!st.brg_run) begin
                    if (scl_s) begin
                        next_st.brg = baud_reload_reg;
                        next_st.brg_run = 1'b1;
                        if (st.bit_cnt == IME_ACK_SLOT) begin
                            next_st.flags.ack_result_bit = sda_s;
                        end else if (!st.sda_low && !sda_s) begin
                            next_st.flags.bus_collision_flag = 1'b1;
                            next_st.flags.buffer_full = 1'b0;
                            next_st.sda_low = 1'b0;
                            next_st.scl_low = 1'b0;
                            next_st.brg_run = 1'b0;
                            next_st.state = ST_IDLE;
                        end
                    end
                end else if (tick) begin
                    next_st.scl_low = 1'b1;
                    next_st.brg = baud_reload_reg;
                    if (st.bit_cnt == IME_ACK_SLOT) begin
                        next_st.flags.serial_port_irq_flag = 1'b1;
                        next_st.brg_run = 1'b0;
                        next_st.state = ST_IDLE;
                    end else begin
                        if (st.bit_cnt == IME_LAST_BIT) begin
                            next_st.flags.buffer_full = 1'b0;
                            next_st.sda_low = 1'b0;
                        end else begin
                            next_st.sda_low = !st.shift_register[6];
                        end
                        next_st.shift_register = {st.shift_register[6:0], 1'b0};
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                        next_st.state = ST_TX_LOW;
                    end
                end
            end
            ST_RX_HIGH: begin
                if (!st.brg_run) begin
                    if (scl_s) begin
                        next_st.brg = baud_reload_reg;
                        next_st.brg_run = 1'b1;
                        next_st.shift_register = {st.shift_register[6:0], sda_s};
                    end
                end else if (tick) begin
                    next_st.scl_low = 1'b1;
                    if (st.bit_cnt == IME_LAST_BIT) begin
                        next_st.reqs.receive_request = 1'b0;
                        next_st.xfer_buffer = st.shift_register;
                        next_st.rx_data = st.shift_register;
                        next_st.rx_push = 1'b1;
                        if (st.flags.buffer_full) begin
                            next_st.flags.receive_overflow_flag = 1'b1;
                        end
                        next_st.flags.buffer_full = 1'b1;
                        next_st.flags.serial_port_irq_flag = 1'b1;
                        next_st.brg_run = 1'b0;
                        next_st.state = ST_IDLE;
                    end else begin
                        next_st.brg = baud_reload_reg;
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                        next_st.state = ST_RX_LOW;
                    end
                end
            end
            ST_ACK_HIGH: begin
                if (!st.brg_run) begin
                    if (scl_s) begin
                        next_st.brg = baud_reload_reg;
                        next_st.brg_run = 1'b1;
                        if (!st.sda_low && !sda_s) begin
                            next_st.flags.bus_collision_flag = 1'b1;
                        end
                    end
                end else if (tick) begin
                    next_st.scl_low = 1'b1;
                    next_st.reqs.ack_sequence_request = 1'b0;
                    next_st.brg_run = 1'b0;
                    next_st.state = ST_IDLE;
                end
            end
            ST_STOP_A: if (!sda_s) begin
                next_st.brg = baud_reload_reg;
                next_st.brg_run = 1'b1;
                next_st.state = ST_STOP_B;
            end
            ST_STOP_B: if (tick) begin
                next_st.scl_low = 1'b0;
                next_st.brg_run = 1'b0;
                next_st.state = ST_STOP_C;
            end
            ST_STOP_C: begin
                if (!st.brg_run) begin
                    if (scl_s) begin
                        next_st.brg = baud_reload_reg;
                        next_st.brg_run = 1'b1;
                    end
                end else if (tick) begin
                    next_st.sda_low = 1'b0;
                    next_st.brg = baud_reload_reg;
                    next_st.state = ST_STOP_D;
                end
            end
            ST_STOP_D: if (tick) begin
                next_st.reqs.stop_request = 1'b0;
                next_st.flags.serial_port_irq_flag = 1'b1;
                next_st.brg_run = 1'b0;
                next_st.state = ST_IDLE;
            end
        endcase

        // disabling the port aborts everything and frees the lines
        if (!port_enable) begin
            next_st.state = ST_IDLE;
            next_st.brg_run = 1'b0;
            next_st.scl_low = 1'b0;
            next_st.sda_low = 1'b0;
            next_st.reqs = '0;
            next_st.flags.begin_detected_bit = 1'b0;
            next_st.flags.end_detected_flag = 1'b0;
            next_st.bus_busy = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.brg <= IME_BAUD_RST;
            st.scl_sync <= 2'h3;
            st.sda_sync <= 2'h3;
            st.scl_prev <= 1'b1;
            st.sda_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // open drain: output value is always low, only enables move
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = st.scl_low;
    assign sda_oe = st.sda_low;
    assign xfer_buffer = st.xfer_buffer;
    assign flags = st.flags;
    assign reqs = st.reqs;
    assign rx_data = fifo_data;
    assign rx_valid = fifo_valid;
endmodule : ime_master
`default_nettype wire

// *** verification/ime_master_checker.sv ***
// concurrent checks on the two-wire master ports
`timescale 1ns/1ps
`default_nettype none
module ime_master_checker
    import ime_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic port_enable,
    input wire logic wr_buffer,
    input wire logic rd_buffer,
    input wire logic set_receive,
    input wire logic ack_value_bit,
    input wire logic clr_write_collision,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [7:0] xfer_buffer,
    input wire ime_flags_t flags,
    input wire ime_req_t reqs
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    a_write_takes: assert property (wr_buffer && port_enable |=> flags.buffer_full || flags.write_collision_flag)
        else $error("buffer write neither loaded nor refused");
    a_coll_keeps: assert property ($rose(flags.write_collision_flag) |-> $stable(xfer_buffer))
        else $error("refused write changed the buffer");
    a_write_collision_flag_sticky: assert property (flags.write_collision_flag && !clr_write_collision && port_enable |=> flags.write_collision_flag)
        else $error("collision flag dropped by itself");
    a_open_drain: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    a_rx_refused: assert property (set_receive && (reqs.stop_request || reqs.ack_sequence_request) |=> !reqs.receive_request)
        else $error("receive taken while busy");
    a_rx_done: assert property ($fell(reqs.receive_request) && port_enable |-> scl_oe ##[0:2] (flags.buffer_full && flags.serial_port_irq_flag))
        else $error("receive end without full, irq or low clock");
    a_rd_clears: assert property (rd_buffer && reqs == 5'h00 && !sda_oe |=> !flags.buffer_full)
        else $error("read left buffer full");
    a_ack_level: assert property (reqs.ack_sequence_request && !scl_oe && $stable(ack_value_bit) |-> sda_oe == !ack_value_bit)
        else $error("ack level wrong while clock high");
    a_stop_done: assert property ($fell(reqs.stop_request) && port_enable |-> flags.end_detected_flag ##[0:1] flags.serial_port_irq_flag)
        else $error("stop ended without end flag and irq");
    a_off_clears: assert property (!port_enable |=> !flags.begin_detected_bit && !flags.end_detected_flag && !scl_oe && !sda_oe)
        else $error("disabled port kept bus state");
endmodule : ime_master_checker
bind ime_master ime_master_checker u_chk (.core_clk, .arst_n, .port_enable, .wr_buffer,
    .rd_buffer, .set_receive, .ack_value_bit, .clr_write_collision, .scl_o, .scl_oe,
    .sda_o, .sda_oe, .xfer_buffer, .flags, .reqs);
`default_nettype wire

// *** verification/ime_slave_model.sv ***
// behavioural bus slave: acks or refuses, sends bytes, may stretch the clock
`timescale 1ns/1ps
`default_nettype none
module ime_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic rd,
    input wire logic nack,
    input wire logic [7:0] tx_byte,
    input wire logic [7:0] stretch,
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] got,
    output logic ack_seen
);
    int bitn = -1;
    initial begin
        scl_oe = 1'b0;
        got = 8'h00;
        ack_seen = 1'b0;
    end
    // start or stop resets the bit count; data only moves while scl is low
    // the master moves sda on the same edge that drops scl, so look once scl has settled
    always @(sda) #1 if (scl === 1'b1) bitn = -1;
    always @(posedge scl) begin
        if (bitn == 8) ack_seen = sda;
        else if (bitn >= 0) got = {got[6:0], sda};
    end
    // stretching holds scl low so the master must wait for the real high level
    always @(negedge scl) begin
        bitn = (bitn == 8) ? 0 : bitn + 1;
        if (stretch != 8'h00) begin
            scl_oe = 1'b1;
            #(int'(stretch) * 20);
            scl_oe = 1'b0;
        end
    end
    // released means floating high through the pull-up
    assign sda_oe = (bitn == 8) ? (!rd && !nack) : (rd && bitn >= 0 && !tx_byte[7 - bitn]);
endmodule : ime_slave_model
`default_nettype wire

// *** verification/tb_ime_master.sv ***
// self-checking bench for the two-wire master transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb_ime_master;
    import ime_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic port_enable = 1'b1;
    logic wr_buffer = 1'b0;
    logic ack_value_bit = 1'b0;
    logic rx_ready = 1'b0;
    logic rd = 1'b0;
    logic nack = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] stretch = 8'h00;
    logic [7:0] baud = 8'h04;
    logic [4:0] pul = 5'h00;
    ime_req_t set_q = 5'h00;
    wire scl_oe, sda_oe, s_scl_oe, s_sda_oe, scl_o, sda_o, rx_valid, ack_seen;
    wire [7:0] xfer_buffer, rx_data, got;
    wire ime_flags_t flags;
    wire ime_req_t reqs;
    wire scl = !(scl_oe || s_scl_oe);
    wire sda = !(sda_oe || s_sda_oe);
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;
    int unread;
    logic [7:0] b;
    logic [7:0] q[$];

    ime_master uut (.core_clk, .arst_n, .port_enable, .baud_reload_reg(baud), .wr_buffer,
        .wr_data, .rd_buffer(pul[4]), .set_begin(set_q.begin_request),
        .set_restart(set_q.restart_request), .set_stop(set_q.stop_request),
        .set_receive(set_q.receive_request), .set_ack_sequence(set_q.ack_sequence_request),
        .ack_value_bit, .clr_irq(pul[3]), .clr_write_collision(pul[2]),
        .clr_overflow(pul[1]), .clr_bus_collision(pul[0]), .scl_i(scl), .scl_o, .scl_oe,
        .sda_i(sda), .sda_o, .sda_oe, .xfer_buffer, .flags, .reqs, .rx_data, .rx_valid,
        .rx_ready);
    ime_slave_model slave (.scl, .sda, .rd, .nack, .tx_byte, .stretch, .scl_oe(s_scl_oe),
        .sda_oe(s_sda_oe), .got, .ack_seen);

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] gv, input logic [7:0] ev);
        n_checks++;
        if (gv !== ev) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, gv, ev);
        end
    endtask : chk
    task automatic chkb(input logic gv, input logic ev);
        chk({7'h00, gv}, {7'h00, ev});
    endtask : chkb
    // requests, clear pulses and a buffer write, given together and held for a single edge
    task automatic act(input logic [4:0] s, input logic [4:0] p, input logic w,
                       input logic [7:0] d);
        @(posedge core_clk);
        set_q <= s;
        pul <= p;
        wr_buffer <= w;
        wr_data <= d;
        @(posedge core_clk);
        set_q <= 5'h00;
        pul <= 5'h00;
        wr_buffer <= 1'b0;
        @(negedge core_clk);
    endtask : act
    task automatic wait_done(input logic irq);
        int i;
        for (i = 0; i < 3000; i++) begin
            if (reqs === 5'h00 && (flags.serial_port_irq_flag === 1'b1 || !irq)) break;
            @(negedge core_clk);
        end
        chkb(i < 3000, 1'b1);
    endtask : wait_done
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // whole run needs a few thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        b = 8'($urandom(11700));
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        chk(flags, 8'h00);
        chk(8'(reqs), 8'h00);
        chk(xfer_buffer, IME_BYTE_RST);
        act(5'h10, 5'h00, 1'b0, 8'h00);
        wait_done(1'b1);
        act(5'h00, 5'h08, 1'b0, 8'h00);
        for (k = 0; k < 2; k++) begin
            b = 8'($urandom) | 8'h01;
            nack <= k[0];
            stretch <= 8'(k * 8);
            act(5'h00, 5'h00, 1'b1, b);
            chkb(flags.buffer_full, 1'b1);
            act(5'h00, 5'h00, 1'b1, ~b);
            chkb(flags.write_collision_flag, 1'b1);
            chk(xfer_buffer, b);
            act(5'h00, 5'h04, 1'b0, 8'h00);
            wait_done(1'b1);
            chkb(flags.buffer_full, 1'b0);
            chkb(flags.ack_result_bit, k[0]);
            chk(got, b);
            act(5'h00, 5'h08, 1'b0, 8'h00);
        end
        tx_byte <= 8'($urandom);
        rd <= 1'b1;
        unread = 0;
        for (k = 0; k < 9; k++) begin
            act(5'h02, 5'h00, 1'b0, 8'h00);
            if (k == 8) begin
                chkb(reqs.receive_request, 1'b0);
            end else begin
                if (k == 0) begin
                    act(5'h00, 5'h00, 1'b1, 8'h00);
                    chkb(flags.write_collision_flag, 1'b1);
                    act(5'h00, 5'h04, 1'b0, 8'h00);
                end
                wait_done(1'b1);
                chk(xfer_buffer, tx_byte);
                chkb(flags.buffer_full, 1'b1);
                chkb(flags.receive_overflow_flag, unread[0]);
                q.push_back(tx_byte);
                tx_byte <= 8'($urandom);
                act(5'h00, k[0] ? 5'h0A : 5'h1A, 1'b0, 8'h00);
                if (!k[0]) chkb(flags.buffer_full, 1'b0);
                unread = k[0];
                @(posedge core_clk);
                ack_value_bit <= (k == 7);
                act(5'h01, 5'h00, 1'b0, 8'h00);
                wait_done(1'b0);
                chkb(ack_seen, k == 7);
            end
        end
        @(posedge core_clk);
        rx_ready <= 1'b1;
        for (k = 0; k < 40 && q.size() > 0; k++) begin
            @(negedge core_clk);
            if (rx_valid === 1'b1) chk(rx_data, q.pop_front());
        end
        chk(8'(q.size()), 8'h00);
        rd <= 1'b0;
        act(5'h04, 5'h00, 1'b0, 8'h00);
        act(5'h00, 5'h00, 1'b1, 8'h5A);
        chkb(flags.write_collision_flag, 1'b1);
        act(5'h02, 5'h00, 1'b0, 8'h00);
        chkb(reqs.receive_request, 1'b0);
        wait_done(1'b1);
        chkb(flags.end_detected_flag, 1'b1);
        act(5'h08, 5'h08, 1'b0, 8'h00);
        wait_done(1'b1);
        chkb(flags.begin_detected_bit, 1'b1);
        // the slave now drives zeros like a rival master, so a released 1 bit loses
        rd <= 1'b1;
        tx_byte <= 8'h00;
        act(5'h00, 5'h00, 1'b1, 8'hFF);
        repeat (40) @(negedge core_clk);
        chkb(flags.bus_collision_flag, 1'b1);
        chk({6'h00, flags.buffer_full, sda_oe}, 8'h00);
        act(5'h00, 5'h01, 1'b0, 8'h00);
        chkb(flags.bus_collision_flag, 1'b0);
        @(posedge core_clk);
        port_enable <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
        chk({6'h00, flags.begin_detected_bit, flags.end_detected_flag}, 8'h00);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        test_done();
    end
endmodule : tb_ime_master
`default_nettype wire
